/* sscs_consts.svh */
/*
  Named constants for the system clock source select block.
  Assumes inclusion by bare name from the package and the top module.
*/
`ifndef SSCS_CONSTS_SVH
`define SSCS_CONSTS_SVH

// Oscillator mode configuration codes
`define SSCS_MODE_LP       3'h0
`define SSCS_MODE_XT       3'h1
`define SSCS_MODE_HS       3'h2
`define SSCS_MODE_RC       3'h3
`define SSCS_MODE_INTERNAL_OSC_BLOCK   3'h4

// Clock source select codes; bit 1 set means internal block
`define SSCS_SRC_DEFAULT   2'h0
`define SSCS_SRC_SEC       2'h1
`define SSCS_SRC_INT_BIT   1

// Internal frequency select
`define SSCS_FREQ_RESET    4'h7
`define SSCS_SLOW_CODE_MAX 4'h2

// Start-up timer terminal count of primary oscillations
`define SSCS_OST_TERM      11'h400
`define SSCS_OST_ONE       11'h001

// Edge counts after enable for ready and for settled frequency
`define SSCS_READY_EDGES   8'h04
`define SSCS_STABLE_EDGES  8'h40
`define SSCS_EDGE_MAX      8'hFF
`define SSCS_EDGE_ONE      8'h01

// Asynchronous input positions in the synchroniser vector
`define SSCS_NUM_IN        5
`define SSCS_IN_PRI        0
`define SSCS_IN_FAST       1
`define SSCS_IN_SLOW       2
`define SSCS_IN_SEC        3
`define SSCS_IN_PIN        4

// Postscaler width and step
`define SSCS_DIV_W         9
`define SSCS_DIV_ONE       9'h001

`endif

/* sscs_pkg.sv */
/*
  Types for the system clock source select block.
  Assumes the constants header is on the include path.
*/
`include "sscs_consts.svh"

package sscs_pkg;

  typedef enum logic [2:0] {
    SW_IDLE      = 3'b000,
    SW_STARTUP   = 3'b001,
    SW_WAIT_FALL = 3'b010,
    SW_HOLD_LOW  = 3'b011,
    SW_UPDATE    = 3'b100
  } sscs_sw_state_type;

  typedef struct packed {
    logic [2:0] osc_mode;
    logic       clkout_en;
    logic       fail_mon_en;
    logic       two_speed_en;
  } sscs_cfg_type;

  typedef struct packed {
    logic fast_ready;
    logic fast_stable;
    logic slow_ready;
    logic fast_active;
    logic slow_active;
    logic ext_clk_active;
  } sscs_status_type;

  typedef struct packed {
    logic [`SSCS_NUM_IN-1:0] sync1;
    logic [`SSCS_NUM_IN-1:0] sync2;
    logic [`SSCS_NUM_IN-1:0] sync3;
    logic [`SSCS_NUM_IN-1:0] flt;
    logic [`SSCS_DIV_W-1:0]  div_cnt;
    logic [10:0]             ost_cnt;
    logic                    ost_run;
    logic                    ost_done;
    logic [7:0]              fast_cnt;
    logic [7:0]              slow_cnt;
    sscs_sw_state_type       sw;
    logic [3:0]              act_sel;
    logic [3:0]              tgt_sel;
    logic [3:0]              freq_sel;
    logic [1:0]              src_sel;
    logic                    int_lvl;
    logic                    tgt_lvl;
    logic                    sys_clk;
    logic                    cpu_hold;
    logic                    fast_en;
    logic                    slow_en;
    logic                    slow_tick;
    logic                    pin_out;
    logic                    pin_oe;
    logic                    clkin_gpio;
    sscs_status_type         status;
  } sscs_state_type;

endpackage

/* sscs_top.sv */
/*
  System clock source select: crystal start-up timer, fast and slow internal
  oscillator control, postscaler, glitch-free internal frequency switching,
  status and run-time source selection.
  Assumes all oscillator inputs are asynchronous to REF_CLK_I and much slower
  than it, and that the power-up logic pulses POR_DONE_I once after reset.
*/
`timescale 1ns/1ps
`include "sscs_consts.svh"
module sscs_top (
  // Clock and reset
  input  wire logic                      REF_CLK_I,
  input  wire logic                      RST_B_I,
  // Configuration
  input  wire sscs_pkg::sscs_cfg_type    CFG_I,
  // Software control writes
  input  wire logic                      SRC_SEL_WR_I,
  input  wire logic [1:0]                SRC_SEL_I,
  input  wire logic                      FREQ_SEL_WR_I,
  input  wire logic [3:0]                FREQ_SEL_I,
  // Start-up events and peripheral slow oscillator request
  input  wire logic                      POR_DONE_I,
  input  wire logic                      WAKE_I,
  input  wire logic                      SLEEP_I,
  input  wire logic                      PERIPH_SLOW_REQ_I,
  // Oscillator inputs
  input  wire logic                      PRIMARY_OSC_I,
  input  wire logic                      FAST_OSC_I,
  input  wire logic                      SLOW_OSC_I,
  input  wire logic                      SEC_OSC_I,
  // Oscillator enables
  output logic                           FAST_OSC_EN_O,
  output logic                           SLOW_OSC_EN_O,
  // System clock and CPU
  output logic                           SYS_CLK_O,
  output logic                           CPU_HOLD_O,
  output logic                           SLOW_TICK_O,
  // Status and control readback
  output sscs_pkg::sscs_status_type      STATUS_O,
  output logic [1:0]                     SRC_SEL_O,
  output logic [3:0]                     FREQ_SEL_O,
  // Output pin and clock input pin
  input  wire logic                      OSC_OUT_PIN_I,
  input  wire logic                      GPIO_OUT_I,
  input  wire logic                      GPIO_OE_I,
  output logic                           OSC_OUT_PIN_O,
  output logic                           OSC_OUT_PIN_OE_O,
  output logic                           GPIO_IN_O,
  output logic                           CLK_IN_PIN_GPIO_O
);
  import sscs_pkg::*;

  sscs_state_type          st_r;
  sscs_state_type          st_nxt;
  logic [`SSCS_NUM_IN-1:0] flt_new;
  logic [`SSCS_NUM_IN-1:0] rise;
  logic                    crystal;
  logic                    fail_or_ts;
  logic                    int_default;
  logic                    int_in_use;
  logic                    int_now;
  logic                    int_out;
  logic                    tgt_now;
  logic                    tgt_ready;
  logic                    sys_lvl;
  logic                    sw_busy;

  // Duplicate codes land on the same tap of one source
  function automatic logic src_level(input logic [3:0] code, input logic fast_lvl,
                                     input logic slow_lvl, input logic [`SSCS_DIV_W-1:0] div);
    case (code)
      4'hF:       src_level = fast_lvl;
      4'hE:       src_level = div[0];
      4'hD:       src_level = div[1];
      4'hC:       src_level = div[2];
      4'hB:       src_level = div[3];
      4'hA, 4'h7: src_level = div[4];
      4'h9, 4'h6: src_level = div[5];
      4'h8, 4'h5: src_level = div[6];
      4'h4:       src_level = div[7];
      4'h3:       src_level = div[8];
      default:    src_level = slow_lvl;
    endcase
  endfunction

  function automatic logic is_slow(input logic [3:0] code);
    is_slow = (code <= `SSCS_SLOW_CODE_MAX);
  endfunction

  // Level filter: a change counts once the second and third stages agree
  for (genvar i = 0; i < `SSCS_NUM_IN; i++) begin : g_filt
    assign flt_new[i] = (st_r.sync2[i] == st_r.sync3[i]) ? st_r.sync3[i] : st_r.flt[i];
    assign rise[i]    = flt_new[i] & ~st_r.flt[i];
  end

  assign crystal     = (CFG_I.osc_mode == `SSCS_MODE_LP) || (CFG_I.osc_mode == `SSCS_MODE_XT) ||
                       (CFG_I.osc_mode == `SSCS_MODE_HS);
  assign fail_or_ts  = CFG_I.fail_mon_en | CFG_I.two_speed_en;
  assign int_default = (CFG_I.osc_mode == `SSCS_MODE_INTERNAL_OSC_BLOCK) ||
                       (crystal && !st_r.ost_done && fail_or_ts);
  assign int_in_use  = st_r.src_sel[`SSCS_SRC_INT_BIT] ||
                       ((st_r.src_sel == `SSCS_SRC_DEFAULT) && int_default);
  assign int_now     = src_level(st_r.act_sel, st_r.flt[`SSCS_IN_FAST], st_r.flt[`SSCS_IN_SLOW], st_r.div_cnt);
  assign tgt_now     = src_level(st_r.tgt_sel, st_r.flt[`SSCS_IN_FAST], st_r.flt[`SSCS_IN_SLOW], st_r.div_cnt);
  assign int_out     = (st_r.sw == SW_HOLD_LOW) ? 1'b0 : int_now;
  assign tgt_ready   = is_slow(st_r.tgt_sel) ? st_r.status.slow_ready : st_r.status.fast_ready;
  assign sw_busy     = (st_r.sw != SW_IDLE);

  always_comb begin
    st_nxt       = st_r;
    st_nxt.sync1 = {OSC_OUT_PIN_I, SEC_OSC_I, SLOW_OSC_I, FAST_OSC_I, PRIMARY_OSC_I};
    st_nxt.sync2 = st_r.sync1;
    st_nxt.sync3 = st_r.sync2;
    st_nxt.flt   = flt_new;

    // Postscaler on the fast oscillator
    if (rise[`SSCS_IN_FAST]) begin
      st_nxt.div_cnt = st_r.div_cnt + `SSCS_DIV_ONE;
    end

    // Software writes; reset value of frequency select set in the flop
    if (SRC_SEL_WR_I) begin
      st_nxt.src_sel = SRC_SEL_I;
    end
    if (FREQ_SEL_WR_I) begin
      st_nxt.freq_sel = FREQ_SEL_I;
    end

    // Crystal start-up timer; a trigger outranks a sleep abort
    if ((POR_DONE_I || WAKE_I) && crystal) begin
      st_nxt.ost_run  = 1'b1;
      st_nxt.ost_done = 1'b0;
      st_nxt.ost_cnt  = '0;
    end else if (POR_DONE_I || WAKE_I || SLEEP_I) begin
      st_nxt.ost_run  = 1'b0;
      st_nxt.ost_done = 1'b0;
    end else if (st_r.ost_run && rise[`SSCS_IN_PRI]) begin
      st_nxt.ost_cnt = st_r.ost_cnt + `SSCS_OST_ONE;
      if (st_nxt.ost_cnt == `SSCS_OST_TERM) begin
        st_nxt.ost_run  = 1'b0;
        st_nxt.ost_done = 1'b1;
      end
    end

    // Oscillator enables
    st_nxt.fast_en = int_in_use && (!is_slow(st_r.act_sel) || !is_slow(st_r.freq_sel) ||
                     (sw_busy && !is_slow(st_r.tgt_sel)));
    st_nxt.slow_en = PERIPH_SLOW_REQ_I || CFG_I.fail_mon_en ||
                     (int_in_use && (is_slow(st_r.act_sel) || is_slow(st_r.freq_sel) ||
                     (sw_busy && is_slow(st_r.tgt_sel))));

    // Edge counters after enable stand in for oscillator run and settle
    if (!st_r.fast_en) begin
      st_nxt.fast_cnt = '0;
    end else if (rise[`SSCS_IN_FAST] && (st_r.fast_cnt != `SSCS_EDGE_MAX)) begin
      st_nxt.fast_cnt = st_r.fast_cnt + `SSCS_EDGE_ONE;
    end
    if (!st_r.slow_en) begin
      st_nxt.slow_cnt = '0;
    end else if (rise[`SSCS_IN_SLOW] && (st_r.slow_cnt != `SSCS_EDGE_MAX)) begin
      st_nxt.slow_cnt = st_r.slow_cnt + `SSCS_EDGE_ONE;
    end
    st_nxt.status.fast_ready  = st_r.fast_en && (st_r.fast_cnt >= `SSCS_READY_EDGES);
    st_nxt.status.fast_stable = st_r.fast_en && (st_r.fast_cnt >= `SSCS_STABLE_EDGES);
    st_nxt.status.slow_ready  = st_r.slow_en && (st_r.slow_cnt >= `SSCS_READY_EDGES);
    st_nxt.slow_tick          = st_r.slow_en && rise[`SSCS_IN_SLOW];

    // Internal frequency switch
    st_nxt.int_lvl = int_now;
    st_nxt.tgt_lvl = tgt_now;
    case (st_r.sw)
      SW_IDLE: begin
        if (st_r.freq_sel != st_r.act_sel) begin
          if (!int_in_use) begin
            st_nxt.act_sel = st_r.freq_sel;
          end else begin
            st_nxt.tgt_sel = st_r.freq_sel;
            st_nxt.tgt_lvl = src_level(st_r.freq_sel, st_r.flt[`SSCS_IN_FAST], st_r.flt[`SSCS_IN_SLOW],
                                       st_r.div_cnt);
            st_nxt.sw      = SW_STARTUP;
          end
        end
      end
      SW_STARTUP: begin
        if (tgt_ready) begin
          st_nxt.sw = SW_WAIT_FALL;
        end
      end
      SW_WAIT_FALL: begin
        if (st_r.int_lvl && !int_now) begin
          st_nxt.sw = SW_HOLD_LOW;
        end
      end
      SW_HOLD_LOW: begin
        if (!st_r.tgt_lvl && tgt_now) begin
          st_nxt.act_sel = st_r.tgt_sel;
          st_nxt.sw      = SW_UPDATE;
        end
      end
      SW_UPDATE: begin
        st_nxt.sw = SW_IDLE;
      end
      default: begin
        st_nxt.sw = SW_IDLE;
      end
    endcase

    // Active oscillator status follows the committed selection
    st_nxt.status.fast_active    = int_in_use && !is_slow(st_r.act_sel);
    st_nxt.status.slow_active    = int_in_use && is_slow(st_r.act_sel);
    st_nxt.status.ext_clk_active = (st_r.src_sel == `SSCS_SRC_DEFAULT) &&
                                   (CFG_I.osc_mode != `SSCS_MODE_INTERNAL_OSC_BLOCK) && (!crystal || st_r.ost_done);

    // System clock source
    if (st_r.src_sel[`SSCS_SRC_INT_BIT]) begin
      sys_lvl = int_out;
    end else if (st_r.src_sel == `SSCS_SRC_SEC) begin
      sys_lvl = st_r.flt[`SSCS_IN_SEC];
    end else if (CFG_I.osc_mode == `SSCS_MODE_INTERNAL_OSC_BLOCK) begin
      sys_lvl = int_out;
    end else if (crystal && !st_r.ost_done) begin
      sys_lvl = fail_or_ts ? int_out : 1'b0;
    end else begin
      sys_lvl = st_r.flt[`SSCS_IN_PRI];
    end
    st_nxt.sys_clk  = sys_lvl;
    st_nxt.cpu_hold = crystal && st_r.ost_run && !fail_or_ts &&
                      (st_r.src_sel == `SSCS_SRC_DEFAULT);

    // Output pin: clock out or general purpose outside crystal modes
    if (!crystal && CFG_I.clkout_en) begin
      st_nxt.pin_out = sys_lvl;
      st_nxt.pin_oe  = 1'b1;
    end else if (!crystal) begin
      st_nxt.pin_out = GPIO_OUT_I;
      st_nxt.pin_oe  = GPIO_OE_I;
    end else begin
      st_nxt.pin_out = 1'b0;
      st_nxt.pin_oe  = 1'b0;
    end
    st_nxt.clkin_gpio = (CFG_I.osc_mode == `SSCS_MODE_INTERNAL_OSC_BLOCK);
  end

  always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      st_r          <= '0;
      st_r.freq_sel <= `SSCS_FREQ_RESET;
      st_r.act_sel  <= `SSCS_FREQ_RESET;
      st_r.tgt_sel  <= `SSCS_FREQ_RESET;
      st_r.src_sel  <= `SSCS_SRC_DEFAULT;
      st_r.sw       <= SW_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign FAST_OSC_EN_O     = st_r.fast_en;
  assign SLOW_OSC_EN_O     = st_r.slow_en;
  assign SYS_CLK_O         = st_r.sys_clk;
  assign CPU_HOLD_O        = st_r.cpu_hold;
  assign SLOW_TICK_O       = st_r.slow_tick;
  assign STATUS_O          = st_r.status;
  assign SRC_SEL_O         = st_r.src_sel;
  assign FREQ_SEL_O        = st_r.freq_sel;
  assign OSC_OUT_PIN_O     = st_r.pin_out;
  assign OSC_OUT_PIN_OE_O  = st_r.pin_oe;
  assign GPIO_IN_O         = st_r.flt[`SSCS_IN_PIN];
  assign CLK_IN_PIN_GPIO_O = st_r.clkin_gpio;

  default clocking @(posedge REF_CLK_I); endclocking
  default disable iff (!RST_B_I);

  ost_term_a: assert property ($rose(st_r.ost_done) |-> st_r.ost_cnt == `SSCS_OST_TERM && !st_r.ost_run)
    else $error("start-up timer finished at a wrong count");
  ost_restart_a: assert property ((POR_DONE_I || WAKE_I) && crystal |=> st_r.ost_run && st_r.ost_cnt == '0)
    else $error("start-up timer did not restart on trigger");
  cpu_hold_a: assert property (CPU_HOLD_O |-> $past(crystal && st_r.ost_run && !fail_or_ts))
    else $error("cpu held without a running start-up count");
  two_speed_run_a: assert property (crystal && st_r.ost_run && fail_or_ts |=> !CPU_HOLD_O)
    else $error("cpu held although two-speed or fail monitor enabled");
  clkout_pin_a: assert property (!crystal && CFG_I.clkout_en |=> OSC_OUT_PIN_OE_O && OSC_OUT_PIN_O == SYS_CLK_O)
    else $error("clock out pin does not follow the system clock");
  fast_enable_a: assert property (int_in_use && !is_slow(st_r.freq_sel) |=> FAST_OSC_EN_O)
    else $error("fast oscillator not enabled for a fast code");
  stable_ready_a: assert property (STATUS_O.fast_stable |-> STATUS_O.fast_ready)
    else $error("fast stable without fast ready");
  slow_enable_a: assert property (PERIPH_SLOW_REQ_I |=> SLOW_OSC_EN_O)
    else $error("slow oscillator off while a peripheral needs it");
  hold_low_a: assert property (st_r.sw == SW_HOLD_LOW && int_in_use |=> !SYS_CLK_O)
    else $error("system clock not held low during switch");
  same_source_a: assert property (st_r.sw == SW_STARTUP && tgt_ready |=> st_r.sw == SW_WAIT_FALL)
    else $error("start-up delay inserted for a running source");
  src_stable_a: assert property (!$past(SRC_SEL_WR_I) |-> $stable(SRC_SEL_O))
    else $error("source select changed without a write");

  // Pin, source, status and start-up abort checks
  clkin_gpio_a: assert property (CFG_I.osc_mode == `SSCS_MODE_INTERNAL_OSC_BLOCK |=> CLK_IN_PIN_GPIO_O)
    else $error("clock input pin not released in internal mode");
  crystal_pin_a: assert property (crystal |=> !OSC_OUT_PIN_OE_O)
    else $error("output pin driven in a crystal mode");
  src_write_a: assert property (SRC_SEL_WR_I |=> SRC_SEL_O == $past(SRC_SEL_I))
    else $error("source select write not taken");
  sec_source_a: assert property (st_r.src_sel == `SSCS_SRC_SEC |=> SYS_CLK_O == $past(st_r.flt[`SSCS_IN_SEC]))
    else $error("system clock does not follow the secondary oscillator");
  slow_ready_a: assert property (STATUS_O.slow_ready |-> $past(SLOW_OSC_EN_O))
    else $error("slow ready without the slow oscillator enabled");
  ost_abort_a: assert property (SLEEP_I && !POR_DONE_I && !WAKE_I |=> !st_r.ost_run && !st_r.ost_done)
    else $error("sleep did not abort the start-up count");
  gpio_pin_a: assert property (!crystal && !CFG_I.clkout_en |=> OSC_OUT_PIN_O == $past(GPIO_OUT_I))
    else $error("output pin does not follow the general purpose drive");

  switch_done_c: cover property (st_r.sw == SW_HOLD_LOW ##1 st_r.sw == SW_UPDATE);
  ost_done_c: cover property ($rose(st_r.ost_done));
  sec_clock_c: cover property (st_r.src_sel == `SSCS_SRC_SEC && $rose(SYS_CLK_O));
  slow_switch_c: cover property ($rose(STATUS_O.slow_active));
  two_speed_c: cover property (crystal && fail_or_ts && st_r.ost_run);

endmodule

/* sscs_osc_model.sv */
/*
  Behavioural model of the oscillators around the clock select block.
  Assumes the bench gates the primary and secondary crystals and the
  device enables gate the internal oscillators; a stopped one rests low.
*/
`timescale 1ns/1ps
module sscs_osc_model #(
  parameter int PRI_HALF_NS  = 50,
  parameter int FAST_HALF_NS = 30,
  parameter int SLOW_HALF_NS = 200,
  parameter int SEC_HALF_NS  = 150
) (
  // Run controls
  input  wire logic fast_en_i,
  input  wire logic slow_en_i,
  input  wire logic pri_run_i,
  input  wire logic sec_run_i,
  // Oscillator levels
  output logic      pri_o,
  output logic      fast_o,
  output logic      slow_o,
  output logic      sec_o
);
  initial begin
    pri_o = 1'b0;
    fast_o = 1'b0;
    slow_o = 1'b0;
    sec_o = 1'b0;
  end
  always #(PRI_HALF_NS) pri_o = pri_run_i ? ~pri_o : 1'b0;
  always #(FAST_HALF_NS) fast_o = fast_en_i ? ~fast_o : 1'b0;
  always #(SLOW_HALF_NS) slow_o = slow_en_i ? ~slow_o : 1'b0;
  always #(SEC_HALF_NS) sec_o = sec_run_i ? ~sec_o : 1'b0;
endmodule

/* sscs_tb.sv */
/*
  Self-checking bench for the clock select block.
  Assumes the oscillator model periods: fast 6, slow 40, primary 10, secondary 30 cycles per half.
*/
`timescale 1ns/1ps
module tb;
  import sscs_pkg::*;
  logic ref_clk, rst_b, src_wr, freq_wr, por, wake, sleep, periph, pin_in, gpio_out, gpio_oe, pri_run, sec_run;
  logic [1:0] src;
  logic [3:0] freq, prev;
  sscs_cfg_type cfg;
  sscs_status_type st;
  logic pri, fast, slow, sec, fast_en, slow_en, sys_clk, hold, tick_o, pin_o, pin_oe, gpio_in, clkin_gpio;
  logic [1:0] src_o;
  logic [3:0] freq_o;
  int num_errors, comparisons, pri_edges, i;
  logic [3:0] freq_seq [7] = '{4'hF, 4'hE, 4'hD, 4'hC, 4'h2, 4'h0, 4'h1};
  sscs_top sscs_top_i (.REF_CLK_I(ref_clk), .RST_B_I(rst_b), .CFG_I(cfg), .SRC_SEL_WR_I(src_wr), .SRC_SEL_I(src),
    .FREQ_SEL_WR_I(freq_wr), .FREQ_SEL_I(freq), .POR_DONE_I(por), .WAKE_I(wake), .SLEEP_I(sleep),
    .PERIPH_SLOW_REQ_I(periph), .PRIMARY_OSC_I(pri), .FAST_OSC_I(fast), .SLOW_OSC_I(slow), .SEC_OSC_I(sec),
    .FAST_OSC_EN_O(fast_en), .SLOW_OSC_EN_O(slow_en), .SYS_CLK_O(sys_clk), .CPU_HOLD_O(hold),
    .SLOW_TICK_O(tick_o), .STATUS_O(st), .SRC_SEL_O(src_o), .FREQ_SEL_O(freq_o), .OSC_OUT_PIN_I(pin_in),
    .GPIO_OUT_I(gpio_out), .GPIO_OE_I(gpio_oe), .OSC_OUT_PIN_O(pin_o), .OSC_OUT_PIN_OE_O(pin_oe),
    .GPIO_IN_O(gpio_in), .CLK_IN_PIN_GPIO_O(clkin_gpio));
  sscs_osc_model sscs_osc_model_i (.fast_en_i(fast_en), .slow_en_i(slow_en), .pri_run_i(pri_run),
    .sec_run_i(sec_run), .pri_o(pri), .fast_o(fast), .slow_o(slow), .sec_o(sec));
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  always @(posedge pri) pri_edges++;
  function automatic int exp_half(input logic [3:0] c);
    // Codes 7 to 5 repeat the taps of A to 8; 4 and 3 continue below them
    return (c <= 4'h2) ? 40 : (c >= 4'h8) ? (6 << (15 - c)) : (6 << (12 - c));
  endfunction
  task automatic tick(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  // Counts level changes of a signal over a window; one change of slack for phase
  task automatic count_edges(input int win, input int exp, input bit use_tick);
    int n;
    logic p;
    n = 0;
    p = use_tick ? tick_o : sys_clk;
    repeat (win) begin
      tick(1);
      if ((use_tick ? tick_o : sys_clk) !== p) n++;
      p = use_tick ? tick_o : sys_clk;
    end
    check((n >= exp - 1 && n <= exp + 1) ? exp : n, exp);
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    tick(1);
    s = 1'b0;
  endtask
  task automatic set_src(input logic [1:0] v);
    src = v;
    pulse(src_wr);
    check(src_o, v);
  endtask
  task automatic set_freq(input logic [3:0] c);
    freq = c;
    pulse(freq_wr);
    check(freq_o, c);
    // Worst case: one period of the old clock, one of the new, plus start-up
    tick(2 * exp_half(prev) + 2 * exp_half(c) + 500);
    check({st.fast_active, st.slow_active}, {c > 4'h2, c <= 4'h2});
    check(c <= 4'h2 ? slow_en : fast_en, 1'b1);
    check(c <= 4'h2 ? st.slow_ready : st.fast_ready, 1'b1);
    if (exp_half(c) <= 48) count_edges(20 * exp_half(c), 20, 1'b0);
    prev = c;
  endtask
  task automatic tally_and_finish;
    $display("Comparisons %0d, mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    #450000;
    num_errors++;
    tally_and_finish;
  end
  initial begin
    {rst_b, src_wr, freq_wr, por, wake, sleep, periph, pin_in, gpio_out, gpio_oe, pri_run, sec_run} = '0;
    src = 2'h0;
    freq = 4'h0;
    prev = 4'h7;
    cfg = '0;
    cfg.osc_mode = 3'h4;
    void'($urandom(82));
    tick(10);
    check(freq_o, 4'h7);
    check(src_o, 2'h0);
    rst_b = 1'b1;
    tick(4);
    check(clkin_gpio, 1'b1);
    check(fast_en, 1'b1);
    repeat (4) begin
      {pin_in, gpio_out, gpio_oe} = 3'($urandom);
      tick(8);
      check({pin_o, pin_oe, gpio_in}, {gpio_out, gpio_oe, pin_in});
    end
    cfg.clkout_en = 1'b1;
    tick(3);
    check({pin_oe, pin_o}, {1'b1, sys_clk});
    foreach (freq_seq[k]) set_freq(freq_seq[k]);
    count_edges(800, 20, 1'b1);
    repeat (3) set_freq(4'($urandom_range(15, 8)));
    set_freq(4'hF);
    tick(900);
    check(st.fast_stable, 1'b1);
    periph = 1'b1;
    tick(4);
    check(slow_en, 1'b1);
    periph = 1'b0;
    tick(4);
    check(slow_en, 1'b0);
    sec_run = 1'b1;
    set_src(2'h1);
    tick(10);
    count_edges(600, 20, 1'b0);
    set_src(2'h3);
    tick(10);
    count_edges(120, 20, 1'b0);
    cfg.osc_mode = 3'h3;
    pri_run = 1'b1;
    set_src(2'h0);
    tick(10);
    count_edges(200, 20, 1'b0);
    pri_run = 1'b0;
    cfg.osc_mode = 3'h0;
    tick(20);
    pulse(por);
    tick(2);
    check({hold, st.ext_clk_active}, 2'b10);
    pri_edges = 0;
    pri_run = 1'b1;
    for (i = 0; i < 22000 && st.ext_clk_active !== 1'b1; i++) tick(1);
    check(pri_edges, 1024);
    check(hold, 1'b0);
    pri_run = 1'b0;
    tick(20);
    pulse(wake);
    pri_run = 1'b1;
    tick(2000);
    check({hold, st.ext_clk_active}, 2'b10);
    pulse(sleep);
    tick(20000);
    check(st.ext_clk_active, 1'b0);
    pri_run = 1'b0;
    cfg.two_speed_en = 1'b1;
    pulse(por);
    tick(20);
    check(hold, 1'b0);
    count_edges(120, 20, 1'b0);
    tally_and_finish;
  end
endmodule
